// ===== core/rfapc_pkg.sv
`default_nettype none
package rfapc_pkg;
	// address values
	localparam logic [15:0] ADDR_BCAST     = 16'hffff;
	localparam logic [15:0] ADDR_ASSOC     = 16'hfffe;
	localparam logic [15:0] PAN_BCAST      = 16'hffff;
	localparam logic [15:0] PAN_RESET      = 16'h3332; // group tag after reset, a plain default
	localparam logic [31:0] DEST_HI_SHORT  = 32'h00000000;
	// host frame types and status codes
	localparam logic [7:0]  TXREQ_LONG     = 8'h00;
	localparam logic [7:0]  TXREQ_SHORT    = 8'h01;
	localparam logic [7:0]  RX_LONG        = 8'h80;
	localparam logic [7:0]  RX_SHORT       = 8'h81;
	localparam logic [7:0]  TX_STATUS      = 8'h89;
	localparam logic [7:0]  ST_TOO_LARGE   = 8'h4a;
	localparam logic [7:0]  ST_OK          = 8'h00;
	// payload limits in bytes
	localparam logic [7:0]  PL_BASE        = 8'h74;
	localparam logic [7:0]  PL_COMPAT      = 8'h5f;
	localparam logic [7:0]  PL_SEC_OVH     = 8'h05;
	localparam logic [7:0]  PL_LONG_ADDR   = 8'h06;
	localparam logic [7:0]  PL_HDR_PLAIN   = 8'h02;
	localparam logic [7:0]  PL_HDR_ENC     = 8'h04;
	// field widths and positions
	localparam int          KEY_W          = 128;
	localparam int          COMPAT_LIMIT_BIT = 0;
	// header/ack modes
	localparam logic [1:0]  HM_HDR_ACK     = 2'h0;
	localparam logic [1:0]  HM_NONE        = 2'h1;
	localparam logic [1:0]  HM_ACK_ONLY    = 2'h2;
	localparam logic [1:0]  HM_HDR_ONLY    = 2'h3;
	// security levels
	localparam logic [2:0]  SEC_NONE       = 3'h0;
	localparam logic [2:0]  SEC_ENC        = 3'h4;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_STAT = 3'b100
	} rfapc_state_type;
endpackage
`default_nettype wire

// ===== core/rfapc_frame_ctl.sv
// The register addresses and the strobed register port are this design's own decisions.
`default_nettype none
module rfapc_frame_ctl
	import rfapc_pkg::*;
(
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	// register port
	input  wire logic [3:0]         regAddr,
	input  wire logic [31:0]        regWdata,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output logic      [31:0]        regRdata,
	// configuration inputs
	input  wire logic [31:0]        serial_low_word,
	input  wire logic [31:0]        serial_high_word,
	input  wire logic [rfapc_pkg::KEY_W-1:0] cipher_key,
	input  wire logic               assocDone,
	// host transmit request
	input  wire logic               frameMode,
	input  wire logic               txReqValid,
	output logic                    txReqReady,
	input  wire logic [7:0]         txReqType,
	input  wire logic [63:0]        txReqDest,
	input  wire logic [7:0]         txReqLen,
	input  wire logic               txReqStatusWanted,
	// transmit header toward the radio
	output logic                    hdrValid,
	input  wire logic               hdrReady,
	output logic [63:0]             hdrSrcAddr,
	output logic                    hdrSrcLong,
	output logic [63:0]             hdrDestAddr,
	output logic                    hdrDestLong,
	output logic [15:0]             hdrPanId,
	output logic                    hdrBcast,
	output logic                    hdrPanBcast,
	output logic                    hdrAckReq,
	output logic                    hdrAppHeader,
	output logic [2:0]              hdrSecLevel,
	output logic [7:0]              hdrLen,
	output logic [rfapc_pkg::KEY_W-1:0] hdrKey,
	// transmit status toward the host
	output logic                    statValid,
	output logic [7:0]              statType,
	output logic [7:0]              statCode,
	// receive classification
	input  wire logic               rxValid,
	input  wire logic               rxSecured,
	input  wire logic               rxSrcLong,
	input  wire logic               rxAppHdrShort,
	output logic                    rxDeliver,
	output logic                    rxDrop,
	output logic [7:0]              rxFrameType,
	// pass-through packetiser
	input  wire logic [7:0]         streamPending,
	output logic [7:0]              payloadLimit
);
	import rfapc_pkg::*;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [3:0] REG_LOCAL  = 4'h0;
	localparam logic [3:0] REG_DESTLO = 4'h1;
	localparam logic [3:0] REG_DESTHI = 4'h2;
	localparam logic [3:0] REG_PAN    = 4'h3;
	localparam logic [3:0] REG_CFG    = 4'h4;
	localparam logic [3:0] REG_STAT   = 4'h5;

	logic [15:0] local_short_addr;
	logic [31:0] dest_low_word;
	logic [31:0] dest_high_word;
	logic [15:0] network_group_tag;
	logic        encrypt_enable;
	logic [7:0]  legacy_compat_bits;
	logic [1:0]  header_ack_mode;
	logic        ackEnable;
	logic [7:0]  refusedCount;
	rfapc_state_type state;

	// local short address; association wins over a same-cycle write
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			local_short_addr <= ADDR_BCAST;
		end else if (assocDone) begin
			local_short_addr <= ADDR_ASSOC;
		end else if (regWr && regAddr == REG_LOCAL) begin
			local_short_addr <= regWdata[15:0];
		end
	end

	// remaining settings
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dest_low_word      <= 32'h00000000;
			dest_high_word     <= 32'h00000000;
			network_group_tag  <= PAN_RESET;
			encrypt_enable     <= 1'b0;
			legacy_compat_bits <= 8'h00;
			header_ack_mode    <= HM_HDR_ACK;
			ackEnable          <= 1'b1;
		end else if (regWr) begin
			case (regAddr)
				REG_DESTLO: dest_low_word <= regWdata;
				REG_DESTHI: dest_high_word <= regWdata;
				REG_PAN:    network_group_tag <= regWdata[15:0];
				REG_CFG: begin
					encrypt_enable     <= regWdata[0];
					header_ack_mode    <= regWdata[5:4];
					ackEnable          <= regWdata[6];
					legacy_compat_bits <= regWdata[15:8];
				end
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			regRdata <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				REG_LOCAL:  regRdata <= {16'h0000, local_short_addr};
				REG_DESTLO: regRdata <= dest_low_word;
				REG_DESTHI: regRdata <= dest_high_word;
				REG_PAN:    regRdata <= {16'h0000, network_group_tag};
				REG_CFG:    regRdata <= {16'h0000, legacy_compat_bits, 1'b0, ackEnable,
				                          header_ack_mode, 3'h0, encrypt_enable};
				REG_STAT:   regRdata <= {16'h0000, refusedCount, 5'h00, state};
				default:    regRdata <= 32'h00000000;
			endcase
		end else begin
			regRdata <= 32'h00000000;
		end
	end

	// ************************************************************
	// payload limit
	// ************************************************************
	function automatic logic hdr_present(input logic [1:0] mode);
		hdr_present = (mode == HM_HDR_ACK) || (mode == HM_HDR_ONLY);
	endfunction

	function automatic logic short_is_reserved(input logic [15:0] a);
		short_is_reserved = (a == ADDR_BCAST) || (a == ADDR_ASSOC);
	endfunction

	function automatic logic dest_is_bcast(input logic isLong, input logic [15:0] shortAddr);
		dest_is_bcast = !isLong && (shortAddr == ADDR_BCAST);
	endfunction

	function automatic logic [7:0] calc_limit(input logic compat, input logic enc, input logic appHdr,
	                                         input logic srcLong, input logic dstLong);
		logic [7:0] lim;
		lim = PL_BASE;
		if (enc) begin
			lim = lim - PL_SEC_OVH - PL_LONG_ADDR;
			if (dstLong) lim = lim - PL_LONG_ADDR;
			if (appHdr) lim = lim - PL_HDR_ENC;
		end else begin
			if (appHdr) lim = lim - PL_HDR_PLAIN;
			if (srcLong) lim = lim - PL_LONG_ADDR;
			if (dstLong) lim = lim - PL_LONG_ADDR;
		end
		if (compat) lim = PL_COMPAT;
		calc_limit = lim;
	endfunction

	// destination selection for the current mode
	logic [63:0] curDest;
	logic        curDestLong;
	logic        srcLong;
	logic        appHdr;
	logic [7:0]  curLimit;
	always_comb begin
		if (frameMode) begin
			curDest     = (txReqType == TXREQ_SHORT) ? {48'h0, txReqDest[15:0]} : txReqDest;
			curDestLong = (txReqType == TXREQ_LONG);
		end else begin
			curDest     = {dest_high_word, dest_low_word};
			curDestLong = (dest_high_word != DEST_HI_SHORT);
		end
		srcLong  = short_is_reserved(local_short_addr) || encrypt_enable;
		appHdr   = hdr_present(header_ack_mode);
		curLimit = calc_limit(legacy_compat_bits[COMPAT_LIMIT_BIT], encrypt_enable, appHdr,
		                      srcLong, curDestLong);
	end

	// the packetiser cuts its stream at this size
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			payloadLimit <= PL_BASE;
		end else begin
			payloadLimit <= curLimit;
		end
	end

	// ************************************************************
	// transmit request handling
	// ************************************************************
	logic tooLarge;
	logic reqLen0;
	logic [7:0] reqLen;
	assign reqLen   = frameMode ? txReqLen : ((streamPending > curLimit) ? curLimit : streamPending);
	assign reqLen0  = (reqLen == 8'h00);
	assign tooLarge = frameMode && (txReqLen > curLimit);
	assign txReqReady = (state == ST_IDLE);

	// one request at a time; header holds until the radio takes it
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (txReqValid && !reqLen0) begin
						if (tooLarge) state <= ST_STAT;
						else state <= ST_SEND;
					end
				end
				ST_SEND: if (hdrReady) state <= (frameMode && txReqStatusWanted) ? ST_STAT : ST_IDLE;
				ST_STAT: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// header fields latched as the request is accepted
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hdrSrcAddr   <= 64'h0;
			hdrSrcLong   <= 1'b0;
			hdrDestAddr  <= 64'h0;
			hdrDestLong  <= 1'b0;
			hdrPanId     <= 16'h0000;
			hdrBcast     <= 1'b0;
			hdrPanBcast  <= 1'b0;
			hdrAckReq    <= 1'b0;
			hdrAppHeader <= 1'b0;
			hdrSecLevel  <= SEC_NONE;
			hdrLen       <= 8'h00;
			hdrKey       <= '0;
			statCode     <= ST_OK;
		end else if (state == ST_IDLE && txReqValid && !reqLen0) begin
			hdrSrcAddr   <= srcLong ? {serial_high_word, serial_low_word}
			                        : {48'h0, local_short_addr};
			hdrSrcLong   <= srcLong;
			hdrDestAddr  <= curDest;
			hdrDestLong  <= curDestLong;
			hdrPanId     <= network_group_tag;
			hdrPanBcast  <= (network_group_tag == PAN_BCAST);
			hdrBcast     <= dest_is_bcast(curDestLong, curDest[15:0]);
			hdrAckReq    <= ackEnable && !dest_is_bcast(curDestLong, curDest[15:0]);
			hdrAppHeader <= appHdr;
			hdrSecLevel  <= encrypt_enable ? SEC_ENC : SEC_NONE;
			hdrLen       <= reqLen;
			hdrKey       <= cipher_key;
			statCode     <= tooLarge ? ST_TOO_LARGE : ST_OK;
		end
	end

	// count of refused requests, visible in the status word
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			refusedCount <= 8'h00;
		end else if (state == ST_IDLE && txReqValid && tooLarge) begin
			refusedCount <= refusedCount + 8'h01;
		end
	end

	// handshake outputs decode the state directly
	assign hdrValid = (state == ST_SEND);
	assign statValid = (state == ST_STAT);
	assign statType = TX_STATUS;

	// ************************************************************
	// receive classification
	// ************************************************************
	// verdict one cycle after the frame; type held between frames
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rxDeliver   <= 1'b0;
			rxDrop      <= 1'b0;
			rxFrameType <= RX_LONG;
		end else begin
			rxDeliver <= rxValid && (rxSecured == encrypt_enable);
			rxDrop    <= rxValid && (rxSecured != encrypt_enable);
			if (rxValid) begin
				if (!encrypt_enable) rxFrameType <= rxSrcLong ? RX_LONG : RX_SHORT;
				else if (appHdr) rxFrameType <= rxAppHdrShort ? RX_SHORT : RX_LONG;
				else rxFrameType <= RX_LONG;
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_compat_limit: assert property (@(posedge mclk) disable iff (sys_rst)
		legacy_compat_bits[COMPAT_LIMIT_BIT] |-> curLimit == PL_COMPAT)
		else $error("compat limit not 95");
	a_plain_max: assert property (@(posedge mclk) disable iff (sys_rst)
		(!legacy_compat_bits[COMPAT_LIMIT_BIT] && !encrypt_enable && !appHdr && !srcLong && !curDestLong)
		|-> curLimit == PL_BASE)
		else $error("plain limit not 116");
	a_enc_cap: assert property (@(posedge mclk) disable iff (sys_rst)
		(!legacy_compat_bits[COMPAT_LIMIT_BIT] && encrypt_enable && !appHdr && !curDestLong)
		|-> curLimit == 8'h69)
		else $error("encrypted limit not 105");
	a_oversize_stat: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == ST_IDLE && txReqValid && tooLarge) |=> statValid && statCode == ST_TOO_LARGE && !hdrValid)
		else $error("oversize frame not refused");
	a_assoc_addr: assert property (@(posedge mclk) disable iff (sys_rst)
		assocDone |=> local_short_addr == ADDR_ASSOC && short_is_reserved(local_short_addr))
		else $error("association address wrong");
	a_long_nobcast: assert property (@(posedge mclk) disable iff (sys_rst)
		hdrValid && hdrDestLong |-> !hdrBcast)
		else $error("long dest marked broadcast");
	a_enc_drop: assert property (@(posedge mclk) disable iff (sys_rst)
		(rxValid && rxSecured != encrypt_enable) |=> rxDrop && !rxDeliver)
		else $error("mismatched frame delivered");
	a_sec_level: assert property (@(posedge mclk) disable iff (sys_rst)
		hdrValid |-> (hdrSecLevel == SEC_NONE) || (hdrSecLevel == SEC_ENC && hdrSrcLong))
		else $error("bad security level");
	a_stream_split: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == ST_IDLE && txReqValid && !frameMode) |-> reqLen <= curLimit)
		else $error("stream packet above limit");
	a_bcast_noack: assert property (@(posedge mclk) disable iff (sys_rst)
		hdrValid && hdrBcast |-> !hdrAckReq)
		else $error("broadcast header asks for ack");
	a_pan_bcast: assert property (@(posedge mclk) disable iff (sys_rst)
		hdrValid |-> hdrPanBcast == (hdrPanId == PAN_BCAST))
		else $error("pan broadcast flag wrong");
	a_hdr_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		hdrValid && !hdrReady |=> hdrValid && $stable(hdrSrcAddr) && $stable(hdrDestAddr))
		else $error("header changed while waiting");
	a_stat_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
		statValid |=> !statValid && txReqReady)
		else $error("status not a single pulse");
	a_plain_recv: assert property (@(posedge mclk) disable iff (sys_rst)
		rxValid && !encrypt_enable |=> rxFrameType == ($past(rxSrcLong) ? RX_LONG : RX_SHORT))
		else $error("plain receive type wrong");
	a_split_fill: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == ST_IDLE && txReqValid && !frameMode && streamPending >= curLimit) |-> reqLen == curLimit)
		else $error("stream packet not filled to limit");
endmodule
`default_nettype wire

// ===== bench/rfapc_radio_model.sv
`default_nettype none
// ****************************************
// radio side of the header handshake
// ****************************************
module rfapc_radio_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// header handshake
	input  wire logic       hdrValid,
	output logic            hdrReady,
	// cycles the radio waits before taking a header
	input  wire logic [3:0] stall
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] waitCnt;

	// take the header once the stall has run out; zero stall answers at once
	assign hdrReady = hdrValid && (waitCnt >= stall);

	// count wait cycles; cleared on each take so the next header stalls again
	always_ff @(posedge mclk) begin
		if (sys_rst || !hdrValid || hdrReady) begin
			waitCnt <= 4'h0;
		end else begin
			waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ===== bench/rfapc_frame_ctl_test.sv
`default_nettype none
// ****************************************
// framer testbench
// ****************************************
module rfapc_frame_ctl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import rfapc_pkg::*;
	// serial words and key are arbitrary test values
	localparam logic [31:0]  SER_LO = 32'h89abcdef;
	localparam logic [31:0]  SER_HI = 32'h01234567;
	localparam logic [127:0] KEY    = 128'h00112233445566778899aabbccddeeff;
	logic         mclk, sys_rst, regWr, regRd, assocDone, frameMode, txReqValid, txReqStatusWanted;
	logic         rxValid, rxSecured, rxSrcLong, rxAppHdrShort, txReqReady, hdrValid, hdrReady;
	logic         hdrSrcLong, hdrDestLong, hdrBcast, hdrPanBcast, hdrAckReq, hdrAppHeader, statValid, rxDeliver, rxDrop;
	logic [3:0]   regAddr, stall;
	logic [31:0]  regWdata, regRdata;
	logic [7:0]   txReqType, txReqLen, streamPending, payloadLimit, statType, statCode, hdrLen, rxFrameType;
	logic [63:0]  txReqDest, hdrSrcAddr, hdrDestAddr;
	logic [15:0]  hdrPanId;
	logic [2:0]   hdrSecLevel;
	logic [127:0] hdrKey;
	int           nMismatch = 0;
	int           checkCount = 0;

	rfapc_frame_ctl dut (.mclk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.serial_low_word(SER_LO), .serial_high_word(SER_HI), .cipher_key(KEY), .assocDone,
		.frameMode, .txReqValid, .txReqReady, .txReqType, .txReqDest, .txReqLen, .txReqStatusWanted,
		.hdrValid, .hdrReady, .hdrSrcAddr, .hdrSrcLong, .hdrDestAddr, .hdrDestLong, .hdrPanId, .hdrBcast,
		.hdrPanBcast, .hdrAckReq, .hdrAppHeader, .hdrSecLevel, .hdrLen, .hdrKey, .statValid, .statType,
		.statCode, .rxValid, .rxSecured, .rxSrcLong, .rxAppHdrShort, .rxDeliver, .rxDrop, .rxFrameType,
		.streamPending, .payloadLimit);
	rfapc_radio_model radio (.mclk, .sys_rst, .hdrValid, .hdrReady, .stall);

	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// a wait that ran out counts as a mismatch and ends the run
	task automatic hang;
		nMismatch++;
		results();
	endtask
	task automatic regW(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic regR(input logic [3:0] a, input logic [31:0] exp);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		chk(regRdata, exp);
	endtask
	// limit is registered, so let it settle before anyone looks
	task automatic cfg(input logic e, input logic [1:0] mm, input logic [7:0] c);
		regW(4'h4, {16'h0, c, 1'b0, 1'b1, mm, 3'h0, e});
		repeat (3) @(posedge mclk);
	endtask
	// request held from one edge until the edge that sees ready
	task automatic send(input logic [7:0] t, input logic [63:0] d, input logic [7:0] l);
		int i;
		@(posedge mclk);
		txReqValid <= 1'b1;
		txReqType <= t;
		txReqDest <= d;
		txReqLen <= l;
		@(negedge mclk);
		for (i = 0; i < 50 && txReqReady !== 1'b1; i++) @(negedge mclk);
		if (i == 50) hang();
		@(posedge mclk);
		txReqValid <= 1'b0;
	endtask
	task automatic waitHdr;
		int i;
		@(negedge mclk);
		for (i = 0; i < 50 && hdrValid !== 1'b1; i++) @(negedge mclk);
		if (i == 50) hang();
	endtask
	task automatic lim(input logic e, input logic [1:0] mm, input logic [7:0] c, input logic dh, input logic [7:0] exp);
		regW(4'h2, {31'h0, dh});
		cfg(e, mm, c);
		@(negedge mclk);
		chk(payloadLimit, exp);
	endtask
	task automatic rx(input logic s, input logic lg, input logic sh, input logic ok, input logic [7:0] ty);
		@(posedge mclk);
		rxValid <= 1'b1;
		rxSecured <= s;
		rxSrcLong <= lg;
		rxAppHdrShort <= sh;
		@(posedge mclk);
		rxValid <= 1'b0;
		@(negedge mclk);
		chk({rxDeliver, rxDrop}, {ok, !ok});
		if (ok) chk(rxFrameType, ty);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic tRegs;
		regR(4'h0, 32'h0000ffff);
		regR(4'h3, {16'h0, PAN_RESET});
		regR(4'h4, 32'h00000040);
		regR(4'h9, 32'h0);
		regW(4'h5, 32'hffffffff);
		regR(4'h5, 32'h1);
	endtask
	task automatic tAddr;
		@(posedge mclk);
		frameMode <= 1'b1;
		cfg(1'b0, HM_NONE, 8'h0);
		regW(4'h0, 32'h1234);
		regW(4'h3, 32'hffff);
		send(TXREQ_SHORT, 64'hffff, 8'h10);
		waitHdr();
		chk({hdrSrcLong, hdrSrcAddr}, {1'b0, 64'h1234});
		chk({hdrBcast, hdrAckReq, hdrDestLong}, 3'b100);
		chk({hdrPanBcast, hdrPanId}, {1'b1, 16'hffff});
		chk(hdrLen, 8'h10);
		regW(4'h3, 32'h0042);
		stall <= 4'h3;
		send(TXREQ_LONG, 64'h001122334455ffff, 8'h10);
		waitHdr();
		chk({hdrBcast, hdrAckReq}, 2'b01);
		chk({hdrDestLong, hdrDestAddr}, {1'b1, 64'h001122334455ffff});
		chk({hdrPanBcast, hdrPanId}, {1'b0, 16'h0042});
		regW(4'h0, 32'hffff);
		send(TXREQ_SHORT, 64'h5, 8'h10);
		waitHdr();
		chk({hdrSrcLong, hdrSrcAddr}, {1'b1, SER_HI, SER_LO});
		regW(4'h0, 32'h1234);
		@(posedge mclk);
		assocDone <= 1'b1;
		@(posedge mclk);
		assocDone <= 1'b0;
		regR(4'h0, 32'hfffe);
		send(TXREQ_SHORT, 64'h5, 8'h10);
		waitHdr();
		chk({hdrSrcLong, hdrSrcAddr}, {1'b1, SER_HI, SER_LO});
		stall <= 4'h0;
	endtask
	task automatic tSec;
		regW(4'h0, 32'h1234);
		cfg(1'b1, HM_HDR_ACK, 8'h0);
		send(TXREQ_SHORT, 64'h5, 8'h20);
		waitHdr();
		chk(hdrSecLevel, SEC_ENC);
		chk(hdrKey, KEY);
		chk({hdrSrcLong, hdrAppHeader}, 2'b11);
		cfg(1'b0, HM_ACK_ONLY, 8'h0);
		send(TXREQ_SHORT, 64'h5, 8'h20);
		waitHdr();
		chk({hdrSecLevel, hdrSrcLong, hdrAppHeader}, {SEC_NONE, 2'b00});
	endtask
	task automatic tRefuse;
		cfg(1'b0, HM_NONE, 8'h0);
		send(TXREQ_SHORT, 64'h5, 8'd117);
		@(negedge mclk);
		chk({statValid, statType, statCode, hdrValid, txReqReady}, {1'b1, TX_STATUS, ST_TOO_LARGE, 2'b00});
		@(negedge mclk);
		chk(statValid, 1'b0);
		@(posedge mclk);
		txReqStatusWanted <= 1'b1;
		send(TXREQ_SHORT, 64'h5, 8'd116);
		waitHdr();
		chk({hdrLen, txReqReady}, {8'd116, 1'b0});
		@(negedge mclk);
		chk({statValid, statCode}, {1'b1, ST_OK});
		@(posedge mclk);
		txReqStatusWanted <= 1'b0;
		cfg(1'b0, HM_NONE, 8'h01);
		send(TXREQ_SHORT, 64'h5, 8'd96);
		@(negedge mclk);
		chk({statValid, statCode}, {1'b1, ST_TOO_LARGE});
		regR(4'h5, 32'h201);
	endtask
	task automatic tLimits;
		@(posedge mclk);
		frameMode <= 1'b0;
		regW(4'h1, 32'h5678);
		lim(1'b0, HM_NONE, 8'h0, 1'b0, 8'd116);
		lim(1'b0, HM_HDR_ONLY, 8'h0, 1'b0, 8'd114);
		lim(1'b0, HM_ACK_ONLY, 8'h0, 1'b1, 8'd110);
		lim(1'b1, HM_ACK_ONLY, 8'h0, 1'b0, 8'd105);
		lim(1'b1, HM_HDR_ACK, 8'h0, 1'b0, 8'd101);
		lim(1'b1, HM_NONE, 8'h0, 1'b1, 8'd99);
		lim(1'b1, HM_HDR_ONLY, 8'h0, 1'b1, 8'd95);
		lim(1'b0, HM_HDR_ACK, 8'h01, 1'b0, 8'd95);
		lim(1'b1, HM_NONE, 8'h01, 1'b1, 8'd95);
		lim(1'b0, HM_NONE, 8'hfe, 1'b0, 8'd116);
	endtask
	task automatic tSplit;
		regW(4'h2, 32'h0);
		streamPending <= 8'd200;
		send(8'h0, 64'h0, 8'h0);
		streamPending <= 8'd84;
		waitHdr();
		chk(hdrLen, 8'd116);
		chk({hdrDestLong, hdrDestAddr}, {1'b0, 64'h5678});
		send(8'h0, 64'h0, 8'h0);
		streamPending <= 8'd0;
		waitHdr();
		chk(hdrLen, 8'd84);
	endtask
	task automatic tRx;
		@(posedge mclk);
		frameMode <= 1'b1;
		cfg(1'b0, HM_HDR_ACK, 8'h0);
		rx(1'b0, 1'b1, 1'b0, 1'b1, RX_LONG);
		rx(1'b0, 1'b0, 1'b0, 1'b1, RX_SHORT);
		rx(1'b1, 1'b0, 1'b0, 1'b0, RX_LONG);
		cfg(1'b1, HM_HDR_ONLY, 8'h0);
		rx(1'b1, 1'b1, 1'b1, 1'b1, RX_SHORT);
		rx(1'b1, 1'b1, 1'b0, 1'b1, RX_LONG);
		rx(1'b0, 1'b0, 1'b0, 1'b0, RX_LONG);
		cfg(1'b1, HM_ACK_ONLY, 8'h0);
		rx(1'b1, 1'b1, 1'b1, 1'b1, RX_LONG);
	endtask

	// main sequence: all inputs set at time zero, reset for 12 cycles
	initial begin
		{sys_rst, regWr, regRd, assocDone, frameMode, txReqValid, txReqStatusWanted} = 7'b1000000;
		{rxValid, rxSecured, rxSrcLong, rxAppHdrShort} = 4'h0;
		{regAddr, stall, regWdata, txReqType, txReqLen, streamPending, txReqDest} = '0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		tRegs();
		tAddr();
		tSec();
		tRefuse();
		tLimits();
		tSplit();
		tRx();
		results();
	end
endmodule
`default_nettype wire
